// ===== bench/twmt_core_tb.sv
module twmt_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import twmt_pkg::*;

  logic clk = 1'h0;
  logic rst = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hready, scl_oe, sda_oe, irq, s_scl_oe, s_sda_oe;
  logic hresp, scl_d, sda_d;
  logic ext_sda = 1'h0;
  logic nack = 1'h0;
  logic stretch = 1'h0;
  logic [7:0] s_byte;
  logic [31:0] rd;
  int s_stops;
  int n_fail = 0;
  int tests_run = 0;
  // Open-drain wires with pull-ups: low while any party pulls.
  wire logic scl_w = !(scl_oe | s_scl_oe);
  wire logic sda_w = !(sda_oe | s_sda_oe | ext_sda);

  // --------------------------------------------------------------
  // Clock, design and partner
  // --------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end

  twmt_core u_dut (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .scl_in(scl_w), .scl_out(scl_d), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_d),
    .sda_oe_out(sda_oe), .irq_out(irq));

  twmt_slave_model u_slave (.scl_in(scl_w), .sda_in(sda_w), .nack_in(nack),
    .stretch_in(stretch), .scl_oe_out(s_scl_oe), .sda_oe_out(s_sda_oe),
    .byte_out(s_byte), .n_stop_out(s_stops));

  // --------------------------------------------------------------
  // Bus and checking tasks
  // --------------------------------------------------------------
  // Compares one value and reports a difference at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Waits for a rising edge with ready high, under a bound.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (hready !== 1'h1) begin
      n_fail++;
      end_sim();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     output logic [31:0] x);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_ready();
    x = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'h0, a, 8'h00, x);
    check(n, x, e);
  endtask

  // Polls the control register until the event flag is up.
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      bus(1'h0, OFS_CONTROL, 8'h00, rd);
      n++;
    end while (rd[CTL_FLAG] !== 1'h1 && n < 8000);
    if (rd[CTL_FLAG] !== 1'h1) begin
      n_fail++;
      end_sim();
    end
  endtask

  // Loads a byte, issues a control value and checks the resulting status.
  task automatic step(input string n, input logic [7:0] d, input logic [7:0] c,
                      input logic [7:0] e);
    logic [31:0] x;
    bus(1'h0, OFS_STATUS, 8'h00, x);
    wr(OFS_DATA, d);
    wr(OFS_CONTROL, c);
    rchk("status_hold", OFS_STATUS, x);
    wait_flag();
    rchk(n, OFS_STATUS, {24'h0, e & STS_CODE_MASK});
    $display("test %s done", n);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    int st;
    int n;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rchk("ctl_reset", OFS_CONTROL, 32'h00);
    rchk("status_reset", OFS_STATUS, 32'hF8);
    rchk("data_reset", OFS_DATA, 32'hFF);
    rchk("role_reset", OFS_ROLE, 32'h0F);
    rchk("unmapped", 8'h10, 32'h00);
    wr(OFS_DATA, 8'h3C);
    rchk("data_kept", OFS_DATA, 32'hFF);
    rchk("collision", OFS_CONTROL, 32'h08);
    wr(OFS_CONTROL, 8'hA5);
    wait_flag();
    rchk("start", OFS_STATUS, {24'h0, STS_START});
    check("irq_set", irq, 1'h1);
    repeat (200) @(posedge clk);
    check("scl_held", scl_oe, 1'h1);
    check("drive_low", {hresp, scl_d, sda_d}, 3'h0);
    rchk("start_kept", OFS_STATUS, {24'h0, STS_START});
    step("addr_ack", 8'hA6, 8'h85, STS_ADDR_ACK);
    check("addr_byte", s_byte, 8'hA6);
    rchk("role_mt", OFS_ROLE, 32'h1F);
    rchk("ctl_after", OFS_CONTROL, 32'h85);
    stretch <= 1'h1;
    step("data_ack", 8'h5C, 8'h85, STS_DATA_ACK);
    check("data_byte", s_byte, 8'h5C);
    stretch <= 1'h0;
    nack <= 1'h1;
    step("data_nack", 8'hC3, 8'h85, STS_DATA_NACK);
    nack <= 1'h0;
    step("rep_start", 8'h00, 8'hA5, STS_REP_START);
    nack <= 1'h1;
    step("addr_nack", 8'h42, 8'h85, STS_ADDR_NACK);
    nack <= 1'h0;
    st = s_stops;
    wr(OFS_CONTROL, 8'h95);
    n = 0;
    do begin
      bus(1'h0, OFS_CONTROL, 8'h00, rd);
      n++;
    end while (rd[CTL_STOP] !== 1'h0 && n < 2000);
    check("stop_clear", rd[CTL_STOP], 1'h0);
    check("stop_seen", s_stops, st + 1);
    check("lines_free", {scl_oe, sda_oe, irq}, 3'h0);
    $display("test stop done");
    ext_sda <= 1'h1;
    repeat (20) @(posedge clk);
    wr(OFS_CONTROL, 8'hA5);
    repeat (1000) @(posedge clk);
    rchk("busy_wait", OFS_CONTROL, 32'h25);
    check("busy_quiet", sda_oe, 1'h0);
    ext_sda <= 1'h0;
    wait_flag();
    rchk("free_start", OFS_STATUS, {24'h0, STS_START});
    $display("test busy done");
    step("addr2_ack", 8'hA6, 8'h85, STS_ADDR_ACK);
    ext_sda <= 1'h1;
    step("arb_lost", 8'hFF, 8'h85, STS_ARB_LOST);
    check("arb_free", {scl_oe, sda_oe}, 2'h0);
    ext_sda <= 1'h0;
    end_sim();
  end

  // Cuts a hang short.
  initial begin
    #400000;
    n_fail++;
    end_sim();
  end
endmodule // twmt_core_tb

// ===== bench/twmt_slave_model.sv
module twmt_slave_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic nack_in,
  input wire logic stretch_in,
  output logic scl_oe_out,
  output logic sda_oe_out,
  output logic [7:0] byte_out,
  output int n_stop_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] shift = 8'h00;
  int cnt = 0;

  // --------------------------------------------------------------
  // Slave receiver on an open-drain bus
  // --------------------------------------------------------------
  // Lines start released; the bench pull-up gives them their level.
  initial begin
    scl_oe_out = 1'h0;
    sda_oe_out = 1'h0;
    byte_out = 8'h00;
    n_stop_out = 0;
  end

  // A start condition restarts the bit count.
  always @(negedge sda_in) begin
    if (scl_in === 1'h1) begin
      cnt = 0;
    end
  end

  // A stop condition ends the frame and is counted.
  always @(posedge sda_in) begin
    if (scl_in === 1'h1) begin
      cnt = 0;
      n_stop_out++;
    end
  end

  // Bits enter MSB first on the rising clock edge, eight to a byte.
  always @(posedge scl_in) begin
    if (cnt < 8) begin
      shift = {shift[6:0], sda_in};
    end
    cnt++;
    if (cnt == 8) begin
      byte_out = shift;
    end
  end

  // Acknowledge pulls data low in the ninth slot; not-acknowledge leaves it high.
  always @(negedge scl_in) begin
    if (cnt == 8) begin
      sda_oe_out = !nack_in;
    end else if (cnt == 9) begin
      sda_oe_out = 1'h0;
      cnt = 0;
    end
  end

  // A slow slave holds the clock low for longer than the master's own low phase.
  always @(negedge scl_in) begin
    if (stretch_in) begin
      scl_oe_out = 1'h1;
      #2000;
      scl_oe_out = 1'h0;
    end
  end
endmodule // twmt_slave_model

// ===== core/twmt_core.sv
// Summary of operation
// R1: Four roles exist; software permits which ones the block may take.
// R2: While the event flag is set the bus transfer stays suspended.
// R3: Software masks status with 0xF8 before comparing codes.
// R4: Master role begins after START; address bit zero picks transmit or receive.
// R5: Software keeps the enable bit set in every advancing control write.
// R6: START request is flag 1, start 1, stop 0, enable 1.
// R7: START is emitted only once the bus is seen free.
// R8: After START the flag sets with status 0x08.
// R9: Writing one clears the flag; address byte is loaded, then flag cleared.
// R10: After the address byte and acknowledge, status is 0x18, 0x20 or 0x38.
// R11: Data write with flag low is dropped and sets write collision.
// R12: Each byte is loaded while flag high, then sent on flag clear.
// R13: STOP request is flag 1, start 0, stop 1, enable 1.
// R14: Repeated START request is flag 1, start 1, stop 0, enable 1.
// R15: Read and not-acknowledge are high; write and acknowledge are low.
// R16: Each packet is eight bits followed by a receiver acknowledge.
// R17: After a repeated START the status is 0x10.
// R18: After a data byte status is 0x28 on acknowledge, 0x30 otherwise.
// R19: The stop bit clears itself once STOP has been driven.
// R20: Lost arbitration reports 0x38 and releases the bus.
// R21: Interrupt request is high while flag and interrupt enable are set.
// R22: Status holds steady while a byte is in flight.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
module twmt_core (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic irq_out
);
  import twmt_pkg::*;

  typedef struct packed {
    twmt_fsm_t fsm;
    logic [1:0] ph;
    logic [TMR_W-1:0] tmr;
    logic [3:0] bitn;
    logic flag;
    logic ack_en;
    logic start;
    logic stop;
    logic wc;
    logic en;
    logic ie;
    logic [7:0] status;
    logic [7:0] data;
    logic [3:0] permit;
    logic [1:0] role;
    logic own;
    logic first;
    logic acked;
    logic scl_oe;
    logic sda_oe;
    logic irq;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [7:0] wr_addr;
  } twmt_core_state_t;

  localparam twmt_core_state_t ST_RESET = '{
    fsm: S_IDLE, ph: 2'h0, tmr: '0, bitn: 4'h0, flag: 1'b0, ack_en: 1'b0,
    start: 1'b0, stop: 1'b0, wc: 1'b0, en: 1'b0, ie: 1'b0, status: STS_NO_INFO,
    data: 8'hFF, permit: ROLE_PERMIT_RESET, role: ROLE_NONE, own: 1'b0,
    first: 1'b0, acked: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0, irq: 1'b0,
    hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0, wr_pend: 1'b0, wr_addr: 8'h00};

  twmt_core_state_t st;
  twmt_core_state_t next_st;
  twmt_bus_view_t view;
  logic ev_start;
  logic ev_byte;
  logic ev_stop;
  logic ev_arb;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Bit sent in slot bitn, most significant first.
  function automatic logic tx_bit(input logic [7:0] d, input logic [3:0] b);
    tx_bit = d[3'(4'h7 - b)];
  endfunction

  // Puts a new code in the status register and keeps the prescaler bits.
  function automatic logic [7:0] with_code(input logic [7:0] code, input logic [7:0] old);
    with_code = (code & STS_CODE_MASK) | (old & ~STS_CODE_MASK);
  endfunction

  // Read multiplexer over the register file.
  function automatic logic [31:0] read_reg(input logic [7:0] a, input twmt_core_state_t s);
    read_reg = 32'h0;
    case (a)
      OFS_CONTROL: read_reg = {24'h0, s.flag, s.ack_en, s.start, s.stop, s.wc, s.en, 1'b0, s.ie};
      OFS_STATUS: read_reg = {24'h0, s.status};
      OFS_DATA: read_reg = {24'h0, s.data};
      OFS_ROLE: read_reg = {26'h0, s.role, s.permit};
      default: read_reg = 32'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Line synchroniser and bus-free detector
  // ------------------------------------------------------------
  twmt_line_monitor u_monitor (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .view_out(view)
  );

  // ------------------------------------------------------------
  // Next-state logic: bus slave, sequencer, events
  // ------------------------------------------------------------

  // Bus writes are applied first so that hardware events set afterwards win.
  always_comb begin
    next_st = st;
    ev_start = 1'b0;
    ev_byte = 1'b0;
    ev_stop = 1'b0;
    ev_arb = 1'b0;
    if (st.wr_pend) begin
      case (st.wr_addr)
        OFS_CONTROL: begin
          if (hwdata_in[CTL_FLAG]) begin
            next_st.flag = 1'b0; // see R9
          end
          next_st.ack_en = hwdata_in[CTL_ACK];
          next_st.start = hwdata_in[CTL_START]; // see R6 see R14
          next_st.stop = hwdata_in[CTL_STOP]; // see R13
          next_st.en = hwdata_in[CTL_EN]; // see R5
          next_st.ie = hwdata_in[CTL_IE];
        end
        OFS_STATUS: next_st.status = with_code(st.status, {6'h00, hwdata_in[1:0]});
        OFS_DATA: begin
          if (st.flag) begin
            next_st.data = hwdata_in[7:0]; // see R12
            next_st.wc = 1'b0;
          end else begin
            next_st.wc = 1'b1; // see R11
          end
        end
        OFS_ROLE: next_st.permit = hwdata_in[3:0]; // see R1
        default: next_st.wr_pend = 1'b0;
      endcase
    end
    next_st.wr_pend = hsel_in && htrans_in[1] && hready_in && hwrite_in;
    next_st.wr_addr = haddr_in[7:0];

    // Sequencer; clearing the enable bit returns it to idle, drops ownership and role, and frees the lines.
    if (!next_st.en) begin
      next_st.fsm = S_IDLE;
      next_st.scl_oe = 1'b0;
      next_st.sda_oe = 1'b0;
      next_st.own = 1'b0;
      next_st.role = ROLE_NONE;
    end else begin
      case (st.fsm)
        S_IDLE: begin
          if (st.start && !st.flag && (st.permit[ROLE_MT] || st.permit[ROLE_MR])) begin
            next_st.fsm = S_WAIT_FREE; // see R1
          end
        end
        S_WAIT_FREE: begin
          if (!view.busy) begin
            next_st.fsm = S_START; // see R7
            next_st.ph = 2'h0;
            next_st.tmr = QUARTER_LOAD;
          end
        end
        S_HOLD: begin
          // Nothing moves on the bus until software clears the flag.
          if (!st.flag) begin // see R2
            next_st.ph = 2'h0;
            next_st.tmr = QUARTER_LOAD;
            next_st.bitn = 4'h0;
            if (st.stop && st.own) begin
              next_st.fsm = S_STOP; // see R13
            end else if (st.stop) begin
              next_st.stop = 1'b0;
              next_st.fsm = st.start ? S_WAIT_FREE : S_IDLE;
            end else if (st.start) begin
              next_st.fsm = st.own ? S_START : S_WAIT_FREE; // see R14
            end else if (st.own && (st.first || st.role == ROLE_CUR_MT)) begin
              next_st.fsm = S_BYTE; // see R12
            end else if (st.own) begin
              next_st.fsm = S_STOP;
            end else begin
              next_st.fsm = S_IDLE;
            end
          end
        end
        S_START, S_BYTE, S_STOP: begin
          if (st.tmr != '0) begin
            next_st.tmr = st.tmr - 1'b1;
          end else begin
            next_st.tmr = QUARTER_LOAD;
            next_st.ph = st.ph + 2'h1;
            case (st.ph)
              2'h0: begin
                if (st.fsm == S_STOP) begin
                  next_st.sda_oe = 1'b1;
                end else if (st.fsm == S_BYTE && st.bitn != BIT_ACK) begin
                  next_st.sda_oe = !tx_bit(st.data, st.bitn); // see R15
                end else begin
                  next_st.sda_oe = 1'b0; // see R16
                end
              end
              2'h1: next_st.scl_oe = 1'b0;
              2'h2: begin
                if (!view.scl) begin
                  // The clock is held low by someone else; wait for it.
                  next_st.tmr = st.tmr;
                  next_st.ph = st.ph;
                end else if (st.fsm == S_START) begin
                  next_st.sda_oe = 1'b1;
                end else if (st.fsm == S_STOP) begin
                  next_st.sda_oe = 1'b0;
                end else if (st.bitn == BIT_ACK) begin
                  next_st.acked = !view.sda; // see R15
                end else if (tx_bit(st.data, st.bitn) && !view.sda) begin
                  ev_arb = 1'b1; // see R20
                end
              end
              default: begin
                if (st.fsm == S_START) begin
                  next_st.scl_oe = 1'b1;
                  ev_start = 1'b1;
                end else if (st.fsm == S_STOP) begin
                  ev_stop = 1'b1;
                end else begin
                  next_st.scl_oe = 1'b1;
                  if (st.bitn == BIT_ACK) begin
                    ev_byte = 1'b1; // see R16
                  end else begin
                    next_st.bitn = st.bitn + 4'h1;
                  end
                end
              end
            endcase
          end
        end
        default: next_st.fsm = S_IDLE;
      endcase
    end

    // Event outcomes; status changes only here and on prescaler writes.
    if (ev_start) begin
      next_st.flag = 1'b1;
      next_st.status = with_code(st.own ? STS_REP_START : STS_START, st.status); // see R8 see R17
      next_st.own = 1'b1;
      next_st.first = 1'b1;
      next_st.fsm = S_HOLD;
    end
    if (ev_byte) begin
      next_st.flag = 1'b1;
      next_st.first = 1'b0;
      next_st.fsm = S_HOLD;
      if (st.first && st.data[0] && st.permit[ROLE_MR]) begin
        next_st.role = ROLE_CUR_MR; // see R4
        next_st.status = with_code(st.acked ? STS_RD_ADDR_ACK : STS_RD_ADDR_NACK, st.status);
      end else if (st.first) begin
        next_st.role = ROLE_CUR_MT; // see R4
        next_st.status = with_code(st.acked ? STS_ADDR_ACK : STS_ADDR_NACK, st.status); // see R10
      end else begin
        next_st.status = with_code(st.acked ? STS_DATA_ACK : STS_DATA_NACK, st.status); // see R18
      end
    end
    if (ev_arb) begin
      next_st.flag = 1'b1;
      next_st.status = with_code(STS_ARB_LOST, st.status); // see R10 see R20
      next_st.sda_oe = 1'b0;
      next_st.scl_oe = 1'b0;
      next_st.own = 1'b0;
      next_st.role = ROLE_NONE;
      next_st.fsm = S_HOLD;
    end
    if (ev_stop) begin
      next_st.stop = 1'b0; // see R19
      next_st.own = 1'b0;
      next_st.role = ROLE_NONE;
      next_st.fsm = st.start ? S_WAIT_FREE : S_IDLE;
    end

    // Interrupt and read answer track the values about to be stored.
    next_st.irq = next_st.flag && next_st.ie; // see R21
    next_st.hrdata = 32'h0;
    if (hsel_in && htrans_in[1] && hready_in && !hwrite_in) begin
      next_st.hrdata = read_reg(haddr_in[7:0], next_st);
    end
    next_st.hreadyout = 1'b1;
    next_st.hresp = 1'b0;
  end

  // State register.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all taken from the state register
  // ------------------------------------------------------------
  assign hrdata_out = st.hrdata;
  assign hreadyout_out = st.hreadyout;
  assign hresp_out = st.hresp;
  assign scl_out = st.hresp; // Open drain: the driven level is always low.
  assign sda_out = st.hresp; // Open drain: the driven level is always low.
  assign scl_oe_out = st.scl_oe;
  assign sda_oe_out = st.sda_oe;
  assign irq_out = st.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_hold_suspend: assert property (st.fsm == S_HOLD && st.flag && next_st.en // see R2
    |=> $stable(scl_oe_out) && $stable(sda_oe_out) && $stable(st.bitn))
    else $error("Bus lines moved while the event flag was set.");

  a_start_bus_free: assert property (st.fsm == S_WAIT_FREE && view.busy && st.en // see R7
    |=> st.fsm != S_START)
    else $error("Start was issued on a busy bus.");

  a_start_code: assert property (ev_start && !st.own // see R8
    |=> st.flag && (st.status & STS_CODE_MASK) == STS_START && st.fsm == S_HOLD)
    else $error("Start did not report its code.");

  a_rep_start_code: assert property (ev_start && st.own // see R17
    |=> st.flag && (st.status & STS_CODE_MASK) == STS_REP_START)
    else $error("Repeated start did not report its code.");

  a_addr_code: assert property (ev_byte && st.first && !st.data[0] // see R10
    |=> st.flag && (st.status & STS_CODE_MASK) == ($past(st.acked) ? STS_ADDR_ACK : STS_ADDR_NACK))
    else $error("Address byte reported a wrong code.");

  a_data_code: assert property (ev_byte && !st.first // see R18
    |=> (st.status & STS_CODE_MASK) == ($past(st.acked) ? STS_DATA_ACK : STS_DATA_NACK))
    else $error("Data byte reported a wrong code.");

  a_write_collide: assert property (st.wr_pend && st.wr_addr == OFS_DATA && !st.flag // see R11
    |=> st.wc && $stable(st.data))
    else $error("Data write with flag low was not refused.");

  a_stop_self_clear: assert property (ev_stop |=> !st.stop && !st.own) // see R19
    else $error("Stop bit stayed set after stop.");

  a_arb_release: assert property (ev_arb // see R20
    |=> !sda_oe_out && !scl_oe_out && (st.status & STS_CODE_MASK) == STS_ARB_LOST)
    else $error("Lost arbitration did not release the bus.");

  a_irq_follow: assert property (irq_out == (st.flag && st.ie)) // see R21
    else $error("Interrupt request did not follow the flag.");

  a_status_steady: assert property (st.fsm == S_BYTE && !ev_byte && !ev_arb && !rst_in // see R22
    && !(st.wr_pend && st.wr_addr == OFS_STATUS) |=> (st.status & STS_CODE_MASK)
    == ($past(st.status) & STS_CODE_MASK))
    else $error("Status changed while a byte was in flight.");

  a_ack_released: assert property (st.fsm == S_BYTE && st.bitn == BIT_ACK && st.ph != 2'h0 // see R15
    |-> !sda_oe_out)
    else $error("Data line driven during the acknowledge slot.");

  c_start_sent: cover property (ev_start && !st.own);
  c_data_acked: cover property (ev_byte && !st.first && st.acked);
  c_rep_start: cover property (ev_start && st.own);
  c_stop_sent: cover property (ev_stop);
  c_arb_lost: cover property (ev_arb);

endmodule // twmt_core

// ===== core/twmt_line_monitor.sv
module twmt_line_monitor (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output twmt_pkg::twmt_bus_view_t view_out
);
  import twmt_pkg::*;

  typedef struct packed {
    logic scl_a;
    logic scl_b;
    logic sda_a;
    logic sda_b;
    logic sda_p;
    logic busy;
  } twmt_mon_state_t;

  twmt_mon_state_t st;
  twmt_mon_state_t next_st;

  // ------------------------------------------------------------
  // Synchronisers and start/stop detection
  // ------------------------------------------------------------

  // The detector reads the second stage of each synchroniser and a third data stage, never the first.
  always_comb begin
    next_st = st;
    next_st.scl_a = scl_in;
    next_st.scl_b = st.scl_a;
    next_st.sda_a = sda_in;
    next_st.sda_b = st.sda_a;
    next_st.sda_p = st.sda_b;
    if (st.scl_b && st.sda_p && !st.sda_b) begin
      next_st.busy = 1'b1; // A falling data line under a high clock opens a frame.
    end else if (st.scl_b && !st.sda_p && st.sda_b) begin
      next_st.busy = 1'b0; // A rising data line under a high clock closes it.
    end
  end

  // Lines idle high, so the stages start high.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st <= '{scl_a: 1'b1, scl_b: 1'b1, sda_a: 1'b1, sda_b: 1'b1, sda_p: 1'b1, busy: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign view_out = '{scl: st.scl_b, sda: st.sda_b, busy: st.busy};

endmodule // twmt_line_monitor

// ===== inc/twmt_pkg.sv
package twmt_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned QUARTER_NS = 625;
  localparam int unsigned QUARTER_CYC = (QUARTER_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 10;
  localparam logic [TMR_W-1:0] QUARTER_LOAD = TMR_W'(QUARTER_CYC - 1);

  // ------------------------------------------------------------
  // Register map, byte offsets within the slave
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ROLE = 8'h0C;

  // Control register bit positions.
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP = 4;
  localparam int CTL_WC = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;

  // Status codes, prescaler bits at zero.
  localparam logic [7:0] STS_START = 8'h08;
  localparam logic [7:0] STS_REP_START = 8'h10;
  localparam logic [7:0] STS_ADDR_ACK = 8'h18;
  localparam logic [7:0] STS_ADDR_NACK = 8'h20;
  localparam logic [7:0] STS_DATA_ACK = 8'h28;
  localparam logic [7:0] STS_DATA_NACK = 8'h30;
  localparam logic [7:0] STS_ARB_LOST = 8'h38;
  localparam logic [7:0] STS_RD_ADDR_ACK = 8'h40;
  localparam logic [7:0] STS_RD_ADDR_NACK = 8'h48;
  localparam logic [7:0] STS_NO_INFO = 8'hF8;
  localparam logic [7:0] STS_CODE_MASK = 8'hF8;

  // Role register: permit bits [3:0], current role [5:4].
  localparam int ROLE_MT = 0;
  localparam int ROLE_MR = 1;
  localparam logic [3:0] ROLE_PERMIT_RESET = 4'hF;
  localparam logic [1:0] ROLE_NONE = 2'h0;
  localparam logic [1:0] ROLE_CUR_MT = 2'h1;
  localparam logic [1:0] ROLE_CUR_MR = 2'h2;

  // Bit index of the acknowledge slot after eight data bits.
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [2:0] {
    S_IDLE,
    S_WAIT_FREE,
    S_START,
    S_BYTE,
    S_STOP,
    S_HOLD
  } twmt_fsm_t;

  // Synchronised view of the two bus lines.
  typedef struct packed {
    logic scl;
    logic sda;
    logic busy;
  } twmt_bus_view_t;

endpackage
